// ==== logic/mgmt_bus_if.sv ====
// management bus between host end and retimer end
`timescale 1ns/10ps
interface mgmt_bus_if;
   logic wrStb;
   logic rdStb;
   logic [7:0] addr;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic rdValid;
   modport device (input wrStb, input rdStb, input addr, input wrData, output rdData, output rdValid);
   modport host (output wrStb, output rdStb, output addr, output wrData, input rdData, input rdValid);
endinterface

// ==== logic/retimer_cfg_device.sv ====
// retimer end: register set steering, channel register copies and eeprom load control
`timescale 1ns/10ps
// Overview of operation
// - master reset bit clears bus-master load state
// - host clears master reset bit before continuing
// - strapped master loads on trigger low, sets done
// - forced-load bit starts load immediately, any strap
// - host forces load only with good eeprom
// - forced load ignored once load completed
// - after master reset, pin or force restarts
// - master disable blocks pin-started load unless busy/done; force still loads
// - host uses disable only before any load; host refuses it only after a force write, not after a pin-started load
// - never set disable and force together
// - broadcast writes all channels, reads one channel
// - selector enable bit maps addresses to channel
// - writes to register_set_selector always hit selector
// - selector reads return meaningless value
// - host writes full selector, upper nibble zero
// - selector codes select shared, channel, broadcast
// - selection persists until selector rewritten
// - four full independent channel register copies
// - writes to read-only fields are ignored
// - selector resets to zero, shared set
module retimer_cfg_device #(
   parameter int NUM_CH = retimer_cfg_pkg::NUM_CH,
   parameter int CH_DEPTH = retimer_cfg_pkg::CH_DEPTH
) (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clkEn,
   // management bus
   mgmt_bus_if.device bus,
   // strap and trigger pins
   input wire logic busRoleStrap,
   input wire logic loadTriggerN,
   // eeprom reader handshake
   output logic eepromLoadReq,
   input wire logic eepromLoadDone,
   // observed state
   output logic loadComplete,
   output logic [7:0] selector
);
   logic [7:0] chMem [NUM_CH][CH_DEPTH];
   logic [7:0] selector_q;
   logic [7:0] ctrl_q;
   logic masterDis_q;
   logic [7:0] rdData_q;
   logic rdValid_q;
   logic [2:0] pinSync_q [2];
   logic [1:0] pinLvl_q;
   logic pinArm_q;
   logic prevForce_q;
   retimer_cfg_pkg::load_state_e state_q;
   retimer_cfg_pkg::load_state_e state_d;

   // selector decode
   wire chEnable = selector_q[retimer_cfg_pkg::SEL_ENABLE_BIT];
   wire bcast = selector_q[retimer_cfg_pkg::SEL_BCAST_BIT];
   wire [1:0] chSel = selector_q[retimer_cfg_pkg::SEL_CH_MSB:retimer_cfg_pkg::SEL_CH_LSB];
   wire selHit = bus.addr == retimer_cfg_pkg::ADDR_SELECTOR;
   wire chAccess = chEnable && !selHit;
   wire sharedWr = bus.wrStb && !chAccess;
   wire chWr = bus.wrStb && chAccess;
   wire ctrlWr = sharedWr && bus.addr == retimer_cfg_pkg::ADDR_LOAD_CTRL;
   wire statWr = sharedWr && bus.addr == retimer_cfg_pkg::ADDR_MASTER_STAT;
   wire selWr = bus.wrStb && selHit;

   // synchronised pin levels: [0] strap, [1] trigger
   wire strapMaster = pinLvl_q[0];
   wire triggerLow = !pinLvl_q[1];
   wire masterRst = ctrl_q[retimer_cfg_pkg::MASTER_RST_BIT];
   wire forceBit = ctrl_q[retimer_cfg_pkg::LOAD_FORCE_BIT];
   wire forceRise = forceBit && !prevForce_q;
   wire pinStart = pinArm_q && triggerLow && !masterDis_q;

   // shared register read value
   function automatic logic [7:0] shared_rd(input logic [7:0] a, input logic [7:0] ctrl,
                                            input logic dis, input logic done);
      logic [7:0] v;
      v = 8'h00;
      if (a == retimer_cfg_pkg::ADDR_LOAD_CTRL)
      begin
         v[retimer_cfg_pkg::MASTER_RST_BIT] = ctrl[retimer_cfg_pkg::MASTER_RST_BIT];
         v[retimer_cfg_pkg::LOAD_FORCE_BIT] = ctrl[retimer_cfg_pkg::LOAD_FORCE_BIT];
      end
      else if (a == retimer_cfg_pkg::ADDR_MASTER_STAT)
      begin
         v[retimer_cfg_pkg::MASTER_DIS_BIT] = dis;
         v[retimer_cfg_pkg::LOAD_DONE_BIT] = done;
      end
      else if (a == retimer_cfg_pkg::ADDR_SELECTOR)
      begin
         v = retimer_cfg_pkg::SELECTOR_RD_VAL;
      end
      return v;
   endfunction

   // pin synchronisers; level accepted once stages two and three agree
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pinSync_q[0] <= 3'b000;
         pinSync_q[1] <= 3'b111;
         pinLvl_q <= 2'b10;
      end
      else if (clkEn)
      begin
         for (int i = 0; i < 2; i++)
         begin
            pinSync_q[i] <= {pinSync_q[i][1:0], (i == 0) ? busRoleStrap : loadTriggerN};
            if (pinSync_q[i][2] == pinSync_q[i][1])
               pinLvl_q[i] <= pinSync_q[i][2];
         end
      end
   end

   // load sequencer next state
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         retimer_cfg_pkg::LD_IDLE:
         begin
            if (!masterRst && (forceRise || pinStart))
               state_d = retimer_cfg_pkg::LD_BUSY;
         end
         retimer_cfg_pkg::LD_BUSY:
         begin
            if (eepromLoadDone)
               state_d = retimer_cfg_pkg::LD_DONE;
         end
         retimer_cfg_pkg::LD_DONE:
         begin
            state_d = retimer_cfg_pkg::LD_DONE;
         end
         default:
         begin
            state_d = retimer_cfg_pkg::LD_IDLE;
         end
      endcase
      // master reset returns to idle and drops completion
      if (masterRst)
         state_d = retimer_cfg_pkg::LD_IDLE;
   end

   // sequencer state and pin arming
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= retimer_cfg_pkg::LD_IDLE;
         pinArm_q <= 1'b0;
         prevForce_q <= 1'b0;
      end
      else if (clkEn)
      begin
         state_q <= state_d;
         prevForce_q <= forceBit;
         // pin path armed while strapped as master or after master reset
         if (masterRst || strapMaster)
            pinArm_q <= 1'b1;
         if (state_q != retimer_cfg_pkg::LD_IDLE && !masterRst)
            pinArm_q <= 1'b0;
      end
   end

   // shared control registers
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         selector_q <= retimer_cfg_pkg::SELECTOR_RST;
         ctrl_q <= retimer_cfg_pkg::CTRL_RST;
         masterDis_q <= 1'b0;
      end
      else if (clkEn)
      begin
         if (selWr)
            selector_q <= bus.wrData;
         if (ctrlWr)
            ctrl_q <= bus.wrData;
         // disable only matters before a load; done bit is read-only
         if (statWr)
            masterDis_q <= bus.wrData[retimer_cfg_pkg::MASTER_DIS_BIT];
      end
   end

   // channel register copies, one or all written
   always_ff @(posedge core_clk)
   begin
      if (clkEn && chWr)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (bcast || chSel == 2'(c))
               chMem[c][bus.addr] <= bus.wrData;
         end
      end
   end

   // read answer one cycle after the strobe
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rdData_q <= 8'h00;
         rdValid_q <= 1'b0;
      end
      else if (clkEn)
      begin
         rdValid_q <= bus.rdStb;
         if (bus.rdStb)
            rdData_q <= chAccess ? chMem[chSel][bus.addr]
                     : shared_rd(bus.addr, ctrl_q, masterDis_q, state_q == retimer_cfg_pkg::LD_DONE);
      end
   end

   // outputs
   assign bus.rdData = rdData_q;
   assign bus.rdValid = rdValid_q;
   assign eepromLoadReq = state_q == retimer_cfg_pkg::LD_BUSY;
   assign loadComplete = state_q == retimer_cfg_pkg::LD_DONE;
   assign selector = selector_q;
endmodule

// ==== logic/retimer_cfg_host.sv ====
// host end: issues register accesses and keeps the host-side usage limits
`timescale 1ns/10ps
module retimer_cfg_host (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clkEn,
   // user command
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [7:0] cmdAddr,
   input wire logic [7:0] cmdData,
   input wire logic strapIsMaster,
   input wire logic eepromKnownGood,
   output logic cmdReady,
   output logic cmdRefused,
   output logic [7:0] rspData,
   output logic rspValid,
   // management bus
   mgmt_bus_if.host bus
);
   logic wrStb_q;
   logic rdStb_q;
   logic [7:0] addr_q;
   logic [7:0] data_q;
   logic clearPend_q;
   logic refused_q;
   logic [7:0] rsp_q;
   logic rspValid_q;
   logic forceSet_q;
   logic loadSeen_q;
   logic disSet_q;

   // checks on the incoming command
   wire isCtrl = cmdAddr == retimer_cfg_pkg::ADDR_LOAD_CTRL;
   wire isStat = cmdAddr == retimer_cfg_pkg::ADDR_MASTER_STAT;
   wire setRst = cmdWrite && isCtrl && cmdData[retimer_cfg_pkg::MASTER_RST_BIT];
   wire setForce = cmdWrite && isCtrl && cmdData[retimer_cfg_pkg::LOAD_FORCE_BIT];
   wire setDis = cmdWrite && isStat && cmdData[retimer_cfg_pkg::MASTER_DIS_BIT];
   wire badRst = setRst && !strapIsMaster;
   wire badForce = setForce && !eepromKnownGood;
   wire badDis = setDis && (forceSet_q || loadSeen_q);
   // force while disable is stored is the undefined pairing
   wire badCombo = setForce && disSet_q;
   wire refuse = badRst || badForce || badDis || badCombo;
   wire busy = wrStb_q || rdStb_q || clearPend_q;
   wire take = cmdValid && cmdReady;

   // new commands wait while the reset bit is still to be cleared
   assign cmdReady = !busy;

   // request issue and automatic clear of the master reset bit
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wrStb_q <= 1'b0;
         rdStb_q <= 1'b0;
         addr_q <= 8'h00;
         data_q <= 8'h00;
         clearPend_q <= 1'b0;
         refused_q <= 1'b0;
         forceSet_q <= 1'b0;
         loadSeen_q <= 1'b0;
         disSet_q <= 1'b0;
      end
      else if (clkEn)
      begin
         wrStb_q <= 1'b0;
         rdStb_q <= 1'b0;
         refused_q <= take && refuse;
         if (take && !refuse)
         begin
            wrStb_q <= cmdWrite;
            rdStb_q <= !cmdWrite;
            addr_q <= cmdAddr;
            // selector upper nibble always written as zero
            data_q <= (cmdAddr == retimer_cfg_pkg::ADDR_SELECTOR) ? (cmdData & retimer_cfg_pkg::SEL_LEGAL_MASK)
                    : cmdData;
            clearPend_q <= setRst;
            if (cmdWrite && isCtrl)
               forceSet_q <= setForce;
            if (cmdWrite && isStat)
               disSet_q <= cmdData[retimer_cfg_pkg::MASTER_DIS_BIT];
            if (setForce)
               loadSeen_q <= 1'b1;
            if (setRst)
               loadSeen_q <= 1'b0;
         end
         else if (clearPend_q && !wrStb_q)
         begin
            wrStb_q <= 1'b1;
            data_q <= data_q & ~(8'h01 << retimer_cfg_pkg::MASTER_RST_BIT);
            clearPend_q <= 1'b0;
         end
      end
   end

   // read answers
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rsp_q <= 8'h00;
         rspValid_q <= 1'b0;
      end
      else if (clkEn)
      begin
         rspValid_q <= bus.rdValid;
         if (bus.rdValid)
            rsp_q <= bus.rdData;
      end
   end

   assign bus.wrStb = wrStb_q;
   assign bus.rdStb = rdStb_q;
   assign bus.addr = addr_q;
   assign bus.wrData = data_q;
   assign cmdRefused = refused_q;
   assign rspData = rsp_q;
   assign rspValid = rspValid_q;
endmodule

// ==== logic/retimer_cfg_pkg.sv ====
// shared constants for the retimer configuration access block
package retimer_cfg_pkg;
   // register addresses
   localparam logic [7:0] ADDR_LOAD_CTRL = 8'h04;
   localparam logic [7:0] ADDR_MASTER_STAT = 8'h05;
   localparam logic [7:0] ADDR_SELECTOR = 8'hff;
   // eeprom_load_control fields
   localparam int LOAD_FORCE_BIT = 4;
   localparam int MASTER_RST_BIT = 5;
   // eeprom_master_status fields
   localparam int LOAD_DONE_BIT = 4;
   localparam int MASTER_DIS_BIT = 7;
   // register_set_selector fields
   localparam int SEL_CH_LSB = 0;
   localparam int SEL_CH_MSB = 1;
   localparam int SEL_ENABLE_BIT = 2;
   localparam int SEL_BCAST_BIT = 3;
   // reset values
   localparam logic [7:0] SELECTOR_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CH_REG_RST = 8'h00;
   // value returned for the write-only selector
   localparam logic [7:0] SELECTOR_RD_VAL = 8'h00;
   // channel count and register depth
   localparam int NUM_CH = 4;
   localparam int CH_DEPTH = 256;
   // upper selector nibble must be zero
   localparam logic [7:0] SEL_LEGAL_MASK = 8'h0f;
   // load sequencer states
   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_BUSY = 2'b01,
      LD_DONE = 2'b10
   } load_state_e;
endpackage

// ==== testbench/retimer_reg_select_eeprom_load_checker.sv ====
// concurrent checks on the management bus and the load state
`timescale 1ns/10ps
module retimer_reg_select_eeprom_load_checker (
   // clock and reset
   input logic core_clk,
   input logic rst,
   // management bus
   input logic wrStb,
   input logic rdStb,
   input logic [7:0] addr,
   input logic [7:0] wrData,
   input logic [7:0] rdData,
   input logic rdValid,
   // device state
   input logic [7:0] selector,
   input logic loadComplete,
   input logic eepromLoadReq,
   input logic eepromLoadDone
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // decoded writes; control bits only reach the shared set
   wire wrSel = wrStb && addr == 8'hff;
   wire wrCtl = wrStb && addr == 8'h04 && !selector[2];
   wire wrStat = wrStb && addr == 8'h05 && !selector[2];
   logic forceQ;
   logic disQ;
   logic forcePrevQ;
   logic rstQ;
   // shadows of force and disable, since a force counts only on a 0 to 1 step
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         forceQ <= 1'b0;
         disQ <= 1'b0;
         forcePrevQ <= 1'b0;
         rstQ <= 1'b0;
      end
      else
      begin
         forcePrevQ <= forceQ;
         if (wrCtl)
            rstQ <= wrData[5];
         if (wrCtl)
            forceQ <= wrData[4];
         if (wrStat)
            disQ <= wrData[7];
      end
   end
   sel_read_a: assert property (rdStb && addr == 8'hff |=> rdValid && rdData == 8'h00)
      else $error("selector read wrong");
   sel_write_a: assert property (wrSel |=> selector == $past(wrData))
      else $error("selector not written");
   sel_hold_a: assert property (!wrSel |=> $stable(selector))
      else $error("selector changed");
   // stored bit acts one edge after the write, state follows one edge later
   mst_reset_a: assert property (wrCtl && wrData[5] |-> ##2 (!loadComplete && !eepromLoadReq))
      else $error("master reset ignored");
   rst_clear_a: assert property (wrCtl && wrData[5] |-> ##2 (wrCtl && !wrData[5]))
      else $error("master reset not cleared");
   // stored reset bit, not the bus write, is what drops completion
   done_hold_a: assert property (loadComplete && !rstQ |=> loadComplete)
      else $error("done flag lost");
   load_end_a: assert property (eepromLoadReq && eepromLoadDone |=> loadComplete && !eepromLoadReq)
      else $error("load did not end");
   done_cause_a: assert property ($rose(loadComplete) |-> $past(eepromLoadDone))
      else $error("done without load");
   force_start_a: assert property (wrCtl && wrData[4] && !wrData[5] && !forceQ
      && !eepromLoadReq && !loadComplete |-> ##2 eepromLoadReq)
      else $error("force did not start load");
   // a stored force step may still start a load, disable only blocks the pin
   dis_block_a: assert property (disQ && !eepromLoadReq && !(forceQ && !forcePrevQ) |=> !eepromLoadReq)
      else $error("load despite disable");
endmodule

// ==== testbench/retimer_reg_select_eeprom_load_tb.sv ====
// both ends joined back to back, driven through the host command port
`timescale 1ns/10ps
module retimer_reg_select_eeprom_load_tb;
   logic core_clk, rst, strap, trigN, eepromLoadDone, good;
   logic cmdValid, cmdWrite, cmdReady, cmdRefused, rspValid, eepromLoadReq, loadComplete, rf;
   logic [7:0] cmdAddr, cmdData, rspData, selector, rv;
   int failures, n_compared;
   mgmt_bus_if busIf();
   retimer_cfg_device retimer_cfg_device_inst (.core_clk, .rst, .clkEn(1'b1), .bus(busIf.device),
      .busRoleStrap(strap), .loadTriggerN(trigN), .eepromLoadReq, .eepromLoadDone, .loadComplete, .selector);
   retimer_cfg_host retimer_cfg_host_inst (.core_clk, .rst, .clkEn(1'b1), .cmdValid, .cmdWrite, .cmdAddr,
      .cmdData, .strapIsMaster(strap), .eepromKnownGood(good), .cmdReady, .cmdRefused, .rspData, .rspValid,
      .bus(busIf.host));
   retimer_reg_select_eeprom_load_checker retimer_reg_select_eeprom_load_checker_inst (.core_clk, .rst,
      .wrStb(busIf.wrStb), .rdStb(busIf.rdStb), .addr(busIf.addr), .wrData(busIf.wrData),
      .rdData(busIf.rdData), .rdValid(busIf.rdValid), .selector, .loadComplete, .eepromLoadReq, .eepromLoadDone);
   // free-running core clock
   always #25 core_clk = ~core_clk;
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one host command; waits out busy, then watches four cycles for refusal or answer
   task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
      for (int n = 0; n < 20 && cmdReady !== 1'b1; n++)
         @(negedge core_clk);
      cmdValid = 1'b1;
      cmdWrite = w;
      cmdAddr = a;
      cmdData = d;
      @(negedge core_clk);
      cmdValid = 1'b0;
      // refusal pulse stands only in the cycle right after the take
      rf = cmdRefused === 1'b1;
      rv = 'x;
      repeat (4)
      begin
         @(negedge core_clk);
         rf |= cmdRefused === 1'b1;
         if (rspValid === 1'b1)
            rv = rspData;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      cmd(1'b0, a, 8'h00);
      check(nm, rv, e);
   endtask
   task automatic pulse_done;
      eepromLoadDone = 1'b1;
      @(negedge core_clk);
      eepromLoadDone = 1'b0;
      @(negedge core_clk);
   endtask
   task automatic t_reset;
      check("selector", selector, 8'h00);
      rd(8'hff, 8'h00, "selector read");
      rd(8'h05, 8'h00, "status idle");
   endtask
   task automatic t_channels;
      for (int c = 0; c < 4; c++)
      begin
         cmd(1'b1, 8'hff, 8'h04 + 8'(c));
         cmd(1'b1, 8'h10, 8'h50 + 8'(c));
      end
      check("selector", selector, 8'h07);
      cmd(1'b1, 8'hff, 8'h00);
      rd(8'h10, 8'h00, "shared 10");
      for (int c = 0; c < 4; c++)
      begin
         cmd(1'b1, 8'hff, 8'h04 + 8'(c));
         rd(8'h10, 8'h50 + 8'(c), "chan 10");
      end
   endtask
   task automatic t_broadcast;
      cmd(1'b1, 8'hff, 8'h0c);
      cmd(1'b1, 8'h20, 8'ha5);
      for (int c = 0; c < 4; c++)
      begin
         cmd(1'b1, 8'hff, 8'h0c + 8'(c));
         rd(8'h20, 8'ha5, "bcast 20");
         rd(8'h10, 8'h50 + 8'(c), "bcast read 10");
      end
      cmd(1'b1, 8'hff, 8'h00);
   endtask
   task automatic t_force;
      cmd(1'b1, 8'h04, 8'h10);
      check("forced busy", 8'(eepromLoadReq), 8'h01);
      pulse_done();
      rd(8'h05, 8'h10, "status done");
      cmd(1'b1, 8'h05, 8'h00);
      rd(8'h05, 8'h10, "done kept");
      cmd(1'b1, 8'h04, 8'h00);
      cmd(1'b1, 8'h04, 8'h10);
      check("no reload", 8'(eepromLoadReq), 8'h00);
      cmd(1'b1, 8'h04, 8'h00);
   endtask
   task automatic t_master;
      strap = 1'b1;
      repeat (4) @(negedge core_clk);
      cmd(1'b1, 8'h04, 8'h20);
      check("done cleared", 8'(loadComplete), 8'h00);
      trigN = 1'b0;
      for (int n = 0; n < 10 && eepromLoadReq !== 1'b1; n++)
         @(negedge core_clk);
      check("pin busy", 8'(eepromLoadReq), 8'h01);
      trigN = 1'b1;
      pulse_done();
      rd(8'h05, 8'h10, "pin done");
   endtask
   task automatic t_disable;
      cmd(1'b1, 8'h04, 8'h20);
      cmd(1'b1, 8'h05, 8'h80);
      trigN = 1'b0;
      repeat (10) @(negedge core_clk);
      check("disabled", 8'(eepromLoadReq), 8'h00);
      rd(8'h05, 8'h80, "disable bit");
      cmd(1'b1, 8'h04, 8'h10);
      check("force while disabled", 8'(rf), 8'h01);
      check("no load while disabled", 8'(eepromLoadReq), 8'h00);
      trigN = 1'b1;
      // let the synced trigger go high before re-enabling, else the armed pin path loads
      repeat (5) @(negedge core_clk);
      cmd(1'b1, 8'h05, 8'h00);
      check("no load after enable", 8'(eepromLoadReq), 8'h00);
   endtask
   task automatic t_refuse;
      strap = 1'b0;
      good = 1'b0;
      cmd(1'b1, 8'h04, 8'h20);
      check("reset refused", 8'(rf), 8'h01);
      cmd(1'b1, 8'h04, 8'h10);
      check("force refused", 8'(rf), 8'h01);
      good = 1'b1;
      cmd(1'b1, 8'h04, 8'h10);
      check("slave force", 8'(eepromLoadReq), 8'h01);
      cmd(1'b1, 8'h05, 8'h80);
      check("combo refused", 8'(rf), 8'h01);
      pulse_done();
      cmd(1'b1, 8'h04, 8'h00);
   endtask
   task automatic give_verdict;
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // main sequence; inputs move on the falling edge
   initial
   begin
      {core_clk, strap, eepromLoadDone, cmdValid, cmdWrite} = '0;
      {cmdAddr, cmdData} = '0;
      {rst, trigN, good} = '1;
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      t_reset();
      t_channels();
      t_broadcast();
      t_force();
      t_master();
      t_disable();
      t_refuse();
      give_verdict();
   end
   // hang guard, well beyond the few hundred cycles the sequence needs
   initial
   begin
      repeat (5000) @(posedge core_clk);
      failures++;
      give_verdict();
   end
endmodule
